// [bench/cs_timed_power_mode_control_tb.sv]
// self-checking bench for the select-timed power-mode block
`timescale 1ns/10ps
`include "cs_mode_params.svh"
// compare two values, count, report a mismatch
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) miss(nm, ex, got); end
// ==========================================================
// bench top
module cs_timed_power_mode_control_tb;
  import cs_mode_pkg::*;
  localparam int FW = 50; // short full-wake count keeps the run brief
  typedef struct {logic [31:0] a; logic [31:0] b; int n; bit chk;} note_t;
  logic clk, rstn, bit_clk, sel_n;
  logic [`RES_W-1:0] sample_a_i, sample_b_i, cur_a, cur_b; // cur: results next frame shows
  logic out_a, oe_a, out_b, oe_b, analog_en, ref_en, powered, hold;
  mode_t mode;
  note_t exp_q[$]; // expected frames, oldest first
  int checks, fail_count, seed, rnd;
  time t_fall; // moment of the latest select fall
  // ==========================================================
  // clock, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  cs_timed_power_mode_control #(.FULL_WAKE_CYC(FW)) i_dut (.clk_sys_i(clk), .rstn_i(rstn),
    .sample_a_i(sample_a_i), .sample_b_i(sample_b_i), .serial_bit_clock_i(bit_clk),
    .conversion_select_n_i(sel_n), .serial_out_a_o(out_a), .serial_out_a_oe_o(oe_a),
    .serial_out_b_o(out_b), .serial_out_b_oe_o(oe_b), .mode_o(mode),
    .analog_en_o(analog_en), .ref_en_o(ref_en), .powered_o(powered), .hold_o(hold));
  host_link_model i_host (.bit_clk_o(bit_clk), .select_n_o(sel_n), .a_i(out_a),
    .a_oe_i(oe_a), .b_i(out_b), .b_oe_i(oe_b));
  // ==========================================================
  // reporting
  task automatic miss(input string nm, input logic [31:0] ex, input logic [31:0] got);
    fail_count++;
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // expected line pattern: zeros, own result, zeros, other result
  function automatic logic [31:0] expw(input logic [`RES_W-1:0] own,
                                       input logic [`RES_W-1:0] oth);
    logic [31:0] w;
    w = '0;
    for (int p = 2; p < 16; p++) w[p] = own[15 - p];
    for (int p = 18; p < 32; p++) w[p] = oth[31 - p];
    return w;
  endfunction
  // power status decoded from the expected mode
  task automatic chk_mode(input mode_t m);
    `CHK("mode", m, mode);
    `CHK("analog on", m == MODE_NORMAL, analog_en);
    `CHK("reference on", m != MODE_FULL, ref_en);
    `CHK("powered", m == MODE_NORMAL, powered);
  endtask
  // new samples, note the expected frame, run it, optionally look inside it
  task automatic run(input int n, input bit chk, input bit mid, input mode_t mm,
                     input logic mh);
    note_t e;
    @(negedge clk);
    rnd = $random(seed);
    sample_a_i = rnd[`RES_W-1:0];
    rnd = $random(seed);
    sample_b_i = rnd[`RES_W-1:0];
    e.a = expw(cur_a, cur_b);
    e.b = expw(cur_b, cur_a);
    e.n = n;
    e.chk = chk;
    exp_q.push_back(e);
    t_fall = $time + 7;
    fork
      i_host.frame(n);
      if (mid)
      begin
        repeat (6) @(negedge clk);
        `CHK("mode mid frame", mm, mode);
        `CHK("hold mid frame", mh, hold);
      end
    join
    // only a frame that reached edge sixteen hands on its sample
    if (n >= 16)
    begin
      cur_a = sample_a_i;
      cur_b = sample_b_i;
    end
    repeat (12) @(negedge clk); // idle gap before the next fall
  endtask
  // ==========================================================
  // watcher: each finished frame takes the oldest note, and is compared with it only when that note asks for a check
  initial
  begin : watch
    note_t e;
    forever
    begin
      @(i_host.frames);
      if (exp_q.size() == 0)
        miss("frame note", 32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        for (int p = 0; p <= e.n && p < 32 && e.chk; p++)
        begin
          `CHK("line a bit", e.a[p], i_host.cap_a[p]);
          `CHK("line b bit", e.b[p], i_host.cap_b[p]);
          `CHK("line a drive", 1'b1, i_host.oea[p]);
          `CHK("line b drive", 1'b1, i_host.oeb[p]);
        end
        if (e.chk && e.n >= 32) `CHK("float at 32", 1'b0, i_host.oea[32] | i_host.oeb[32]);
        if (e.chk) `CHK("float at rise", 1'b0, i_host.rise_oe);
      end
    end
  end
  // hang guard
  initial
  begin
    #1000000;
    miss("timeout", 32'h0, 32'h1);
    print_verdict;
  end
  // ==========================================================
  // main sequence
  initial
  begin
    seed = 90420;
    rstn = 1'b0;
    sample_a_i = '0;
    sample_b_i = '0;
    cur_a = '0;
    cur_b = '0;
    checks = 0;
    fail_count = 0;
    repeat (8) @(negedge clk);
    chk_mode(MODE_NORMAL);
    `CHK("hold at reset", 1'b0, hold);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    run(32, 1, 0, MODE_NORMAL, 1'b0);
    run(32, 1, 0, MODE_NORMAL, 1'b0);
    run(20, 1, 0, MODE_NORMAL, 1'b0);
    run(12, 1, 1, MODE_NORMAL, 1'b1);
    run(16, 1, 0, MODE_NORMAL, 1'b0);
    run(1, 1, 0, MODE_NORMAL, 1'b0);
    chk_mode(MODE_NORMAL);
    run(5, 1, 0, MODE_NORMAL, 1'b0);
    chk_mode(MODE_PARTIAL);
    run(1, 0, 0, MODE_NORMAL, 1'b0);
    chk_mode(MODE_PARTIAL);
    run(12, 0, 1, MODE_WAKE_PART, 1'b0);
    chk_mode(MODE_NORMAL);
    run(5, 1, 0, MODE_NORMAL, 1'b0);
    run(5, 0, 0, MODE_NORMAL, 1'b0);
    chk_mode(MODE_FULL);
    run(3, 0, 0, MODE_NORMAL, 1'b0);
    chk_mode(MODE_FULL);
    run(12, 0, 0, MODE_NORMAL, 1'b0);
    `CHK("waking from full", MODE_WAKE_FULL, mode);
    `CHK("powered while waking", 1'b0, powered);
    for (rnd = 0; rnd < 200 && mode !== MODE_NORMAL; rnd++) @(negedge clk);
    `CHK("wake time", 1'b1, ($time - t_fall) / 100 >= FW && ($time - t_fall) / 100 <= FW + 8);
    chk_mode(MODE_NORMAL);
    run(32, 1, 0, MODE_NORMAL, 1'b0);
    `CHK("notes left", 32'h0, exp_q.size());
    print_verdict;
  end
endmodule // cs_timed_power_mode_control_tb

// [bench/host_link_model.sv]
// host serial master model: drives select and link clock, captures both lines
`timescale 1ns/10ps
// ==========================================================
// host side of the serial link
module host_link_model (
  // link pins driven by the host
  output logic bit_clk_o,
  output logic select_n_o,
  // converter lines as the host sees them
  input wire logic a_i,
  input wire logic a_oe_i,
  input wire logic b_i,
  input wire logic b_oe_i
);
  logic last_a, last_b; // last driven level per line
  logic wa, wb; // line level at the host
  logic [32:0] cap_a, cap_b, oea, oeb; // captures per bit position
  logic rise_oe; // a line still driven just after select rise
  int frames; // completed frames
  // no pull on the lines, so a released line shows the inverse of its last level
  assign wa = a_oe_i ? a_i : ~last_a;
  assign wb = b_oe_i ? b_i : ~last_b;
  // remember the last driven level
  always @(a_i or a_oe_i or b_i or b_oe_i)
  begin
    if (a_oe_i) last_a = a_i;
    if (b_oe_i) last_b = b_i;
  end
  // idle state: clock stands still, select high; the link side has no reset,
  // so a clean select rise just after start clears its count and shifters
  initial
  begin
    bit_clk_o = 1'b1;
    select_n_o = 1'b0;
    frames = 0;
    #1;
    select_n_o = 1'b1;
    last_a = 1'b0;
    last_b = 1'b0;
  end
  // sample both lines and their drive for one position
  task automatic grab(input int k);
    cap_a[k] = wa;
    cap_b[k] = wb;
    oea[k] = a_oe_i;
    oeb[k] = b_oe_i;
  endtask
  // one frame: select low for exactly n falling edges, then raised
  task automatic frame(input int n);
    #7; // phase offset against the system clock
    select_n_o = 1'b0;
    #40;
    grab(0);
    for (int k = 1; k <= n; k++)
    begin
      bit_clk_o = 1'b0;
      #40;
      grab(k);
      bit_clk_o = 1'b1;
      #40;
    end
    // short frames still keep select low long enough for the slow side
    if (n < 4) #(280 - 80 * n);
    select_n_o = 1'b1;
    #1;
    rise_oe = a_oe_i | b_oe_i;
    frames++;
  endtask
endmodule // host_link_model

// [hw/cs_mode_params.svh]
// constants for the select-timed power-mode and read-framing block
`ifndef CS_MODE_PARAMS_SVH
`define CS_MODE_PARAMS_SVH

// ==========================================================
// frame layout, in serial clock falling edges
`define RES_W 14
`define EDGE_FIRST 6'd1
`define EDGE_GLITCH 6'd2
`define EDGE_KEEP 6'd10
`define EDGE_DONE 6'd16
`define EDGE_TRAIL 6'd18
`define EDGE_END 6'd32
`define BIT_TOP_OWN 6'd15
`define BIT_TOP_OTHER 6'd31

// ==========================================================
// timing on the system clock
`define SYS_PERIOD_NS 100
`define PART_WAKE_NS 200
`define FULL_WAKE_NS 6000000
`define PART_WAKE_CYC ((`PART_WAKE_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define FULL_WAKE_CYC ((`FULL_WAKE_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define WAKE_CNT_W 24

`endif

// [hw/cs_mode_pkg.sv]
// types shared by the select-timed power-mode block
`include "cs_mode_params.svh"
package cs_mode_pkg;

  // ==========================================================
  // power modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PARTIAL = 3'b001,
    MODE_FULL = 3'b010,
    MODE_WAKE_PART = 3'b011,
    MODE_WAKE_FULL = 3'b100
  } mode_t;

  // ==========================================================
  // edge milestones reached in the current frame
  typedef struct packed {
    logic reach16;
    logic reach10;
    logic reach2;
    logic reach1;
  } edge_flags_t;

  // one result per channel
  typedef struct packed {
    logic [`RES_W-1:0] a;
    logic [`RES_W-1:0] b;
  } result_pair_t;

endpackage

// [hw/cs_timed_power_mode_control.sv]
// select-timed power-mode control and serial read framing of a dual converter
`timescale 1ns/10ps
`include "cs_mode_params.svh"

module cs_timed_power_mode_control #(
  parameter int FULL_WAKE_CYC = `FULL_WAKE_CYC
) (
  // system side
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [`RES_W-1:0] sample_a_i,
  input wire logic [`RES_W-1:0] sample_b_i,
  // serial link pins
  input wire logic serial_bit_clock_i,
  input wire logic conversion_select_n_i,
  output logic serial_out_a_o,
  output logic serial_out_a_oe_o,
  output logic serial_out_b_o,
  output logic serial_out_b_oe_o,
  // power and track-hold status
  output cs_mode_pkg::mode_t mode_o,
  output logic analog_en_o,
  output logic ref_en_o,
  output logic powered_o,
  output logic hold_o
);
  import cs_mode_pkg::*;

  // ==========================================================
  // link domain: edge count, shifters, milestones
  logic [5:0] cnt_r; // falling edges since select fell
  logic [5:0] cnt_nxt; // count after the coming edge
  logic out_a_r; // bit on line a
  logic out_b_r; // bit on line b
  edge_flags_t flags_r; // milestones, cleared from system side
  logic clr_link_r; // system-side clear of milestones
  result_pair_t res_r; // committed results, stable during frames

  // choose the bit for frame position n on one line
  function automatic logic bit_at(input logic [5:0] n,
                                  input logic [`RES_W-1:0] own,
                                  input logic [`RES_W-1:0] oth);
    logic [5:0] i;
    i = 6'd0;
    bit_at = 1'b0;
    // positions 0,1 and 16,17 are zeros
    if (n >= `EDGE_GLITCH && n < `EDGE_DONE)
    begin
      i = `BIT_TOP_OWN - n;
      bit_at = own[i[3:0]];
    end
    else if (n >= `EDGE_TRAIL && n < `EDGE_END)
    begin
      i = `BIT_TOP_OTHER - n;
      bit_at = oth[i[3:0]];
    end
  endfunction

  // saturate at the end of a dual read
  assign cnt_nxt = (cnt_r == `EDGE_END) ? cnt_r : cnt_r + 6'd1;

  // edge counter; select high ends the frame without needing a clock
  always_ff @(negedge serial_bit_clock_i or posedge conversion_select_n_i)
  begin
    if (conversion_select_n_i)
      cnt_r <= 6'd0;
    else
      cnt_r <= cnt_nxt;
  end

  // shifters; cleared value is the first leading zero
  always_ff @(negedge serial_bit_clock_i or posedge conversion_select_n_i)
  begin
    if (conversion_select_n_i)
    begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end
    else
    begin
      out_a_r <= bit_at(cnt_nxt, res_r.a, res_r.b);
      out_b_r <= bit_at(cnt_nxt, res_r.b, res_r.a);
    end
  end

  // milestones outlive the frame so the system side can read them
  always_ff @(negedge serial_bit_clock_i or posedge clr_link_r)
  begin
    if (clr_link_r)
      flags_r <= '0;
    else if (!conversion_select_n_i)
    begin
      if (cnt_nxt == `EDGE_FIRST)
        flags_r.reach1 <= 1'b1;
      if (cnt_nxt == `EDGE_GLITCH)
        flags_r.reach2 <= 1'b1;
      if (cnt_nxt == `EDGE_KEEP)
        flags_r.reach10 <= 1'b1;
      if (cnt_nxt == `EDGE_DONE)
        flags_r.reach16 <= 1'b1;
    end
  end

  // drive from select fall until select rise or edge 32
  assign serial_out_a_oe_o = !conversion_select_n_i && (cnt_r != `EDGE_END);
  assign serial_out_b_oe_o = !conversion_select_n_i && (cnt_r != `EDGE_END);
  assign serial_out_a_o = out_a_r;
  assign serial_out_b_o = out_b_r;

  // ==========================================================
  // system domain: synchronisers
  logic cs_meta_r; // first stage, read only by cs_s_r
  logic cs_s_r; // select, synchronised
  logic cs_d_r; // select, one cycle later
  edge_flags_t fl_meta_r; // first stage, read only by fl_s_r
  edge_flags_t fl_s_r; // milestones, synchronised
  logic cs_fall;
  logic cs_rise;

  // both paths have equal depth so milestones are settled at the rise
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cs_meta_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      fl_meta_r <= '0;
      fl_s_r <= '0;
    end
    else
    begin
      cs_meta_r <= conversion_select_n_i;
      cs_s_r <= cs_meta_r;
      cs_d_r <= cs_s_r;
      fl_meta_r <= flags_r;
      fl_s_r <= fl_meta_r;
    end
  end

  assign cs_fall = cs_d_r && !cs_s_r;
  assign cs_rise = !cs_d_r && cs_s_r;

  // clear in reset too: link flops have no reset and would stay unknown at power-on
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      clr_link_r <= 1'b1;
    else if (cs_rise)
      clr_link_r <= 1'b1;
    else if (fl_s_r == '0)
      clr_link_r <= 1'b0;
  end

  // ==========================================================
  // sampling and results
  result_pair_t samp_r; // taken at select fall
  // samples are taken three system clocks after the pin falls
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      samp_r <= '0;
    else if (cs_fall)
      samp_r <= '{a: sample_a_i, b: sample_b_i};
  end

  // a result becomes readable only once its frame passed edge 16
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      res_r <= '0;
    else if (cs_rise && fl_s_r.reach16)
      res_r <= samp_r;
  end

  // ==========================================================
  // wake timer, counts from select fall
  logic [`WAKE_CNT_W-1:0] wake_cnt_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      wake_cnt_r <= '0;
    else if (cs_fall)
      wake_cnt_r <= '0;
    else if (wake_cnt_r != {`WAKE_CNT_W{1'b1}})
      wake_cnt_r <= wake_cnt_r + `WAKE_CNT_W'(1);
  end

  // ==========================================================
  // mode machine
  mode_t mode_r;
  // power-on mode is undefined; normal is taken, the host dummies anyway
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      mode_r <= MODE_NORMAL;
    else if (cs_fall)
    begin
      // a fall in power-down starts the analog wake
      if (mode_r == MODE_PARTIAL)
        mode_r <= MODE_WAKE_PART;
      else if (mode_r == MODE_FULL)
        mode_r <= MODE_WAKE_FULL;
    end
    else if (cs_rise)
    begin
      unique case (mode_r)
        MODE_NORMAL:
          // early rises are glitches, late rises only abort
          if (fl_s_r.reach2 && !fl_s_r.reach10)
            mode_r <= MODE_PARTIAL;
        MODE_WAKE_PART:
          if (!fl_s_r.reach2)
            mode_r <= MODE_PARTIAL;
          else if (!fl_s_r.reach10)
            mode_r <= MODE_FULL;
          else
            mode_r <= MODE_NORMAL;
        MODE_WAKE_FULL:
          if (!fl_s_r.reach10)
            mode_r <= MODE_FULL;
        MODE_PARTIAL, MODE_FULL:
          mode_r <= mode_r; // rise without a seen fall
        default:
          mode_r <= MODE_NORMAL;
      endcase
    end
    else if (mode_r == MODE_WAKE_FULL && cs_s_r &&
             wake_cnt_r >= `WAKE_CNT_W'(FULL_WAKE_CYC))
      mode_r <= MODE_NORMAL; // long wake done after a valid dummy
  end

  // partial keeps the reference alive, full drops everything
  assign analog_en_o = (mode_r != MODE_PARTIAL) && (mode_r != MODE_FULL);
  assign ref_en_o = (mode_r != MODE_FULL);
  assign powered_o = (mode_r == MODE_NORMAL) ||
                     (mode_r == MODE_WAKE_PART && wake_cnt_r >= `WAKE_CNT_W'(`PART_WAKE_CYC));
  assign mode_o = mode_r;

  // ==========================================================
  // track-and-hold: hold from select fall until edge 16, or until edge 1 while waking from partial
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      hold_o <= 1'b0;
    else
      hold_o <= !cs_s_r && !fl_s_r.reach16 &&
                !(mode_r == MODE_WAKE_PART && fl_s_r.reach1);
  end

  // ==========================================================
  // checks, link domain
  property p_oe_frame;
    @(negedge serial_bit_clock_i) disable iff (conversion_select_n_i)
      (cnt_r < `EDGE_END) |-> (serial_out_a_oe_o && serial_out_b_oe_o);
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("outputs not driven inside frame");

  property p_msb_pos;
    @(negedge serial_bit_clock_i) disable iff (conversion_select_n_i)
      (cnt_r == 6'd2) |-> (out_a_r == res_r.a[13] && out_b_r == res_r.b[13]);
  endproperty
  a_msb_pos: assert property (p_msb_pos)
    else $error("msb not at position two");

  property p_trail;
    @(negedge serial_bit_clock_i) disable iff (conversion_select_n_i)
      (cnt_r == 6'd15) |=> (!out_a_r && !out_b_r) ##1 (!out_a_r && !out_b_r);
  endproperty
  a_trail: assert property (p_trail)
    else $error("trailing zeros missing");

  property p_other;
    @(negedge serial_bit_clock_i) disable iff (conversion_select_n_i)
      (cnt_r == 6'd31) |-> (out_a_r == res_r.b[0] && out_b_r == res_r.a[0]);
  endproperty
  a_other: assert property (p_other)
    else $error("other channel lsb wrong");

  property p_float_end;
    @(posedge serial_bit_clock_i) disable iff (conversion_select_n_i)
      (cnt_r == `EDGE_END) |-> !serial_out_a_oe_o && !serial_out_b_oe_o && !out_a_r && !out_b_r;
  endproperty
  a_float_end: assert property (p_float_end)
    else $error("output not floated at edge 32");

  // ==========================================================
  // checks, system domain
  property p_keep_normal;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_rise && mode_r == MODE_NORMAL && (fl_s_r.reach10 || !fl_s_r.reach2))
        |=> mode_r == MODE_NORMAL;
  endproperty
  a_keep_normal: assert property (p_keep_normal)
    else $error("normal mode left on glitch or late rise");

  property p_to_partial;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_rise && mode_r == MODE_NORMAL && fl_s_r.reach2 && !fl_s_r.reach10)
        |=> mode_r == MODE_PARTIAL ##1 !analog_en_o && ref_en_o;
  endproperty
  a_to_partial: assert property (p_to_partial)
    else $error("partial power-down not entered");

  property p_to_full;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_rise && mode_r == MODE_WAKE_PART && fl_s_r.reach2 && !fl_s_r.reach10)
        |=> mode_r == MODE_FULL && !ref_en_o;
  endproperty
  a_to_full: assert property (p_to_full)
    else $error("full power-down not entered");

  property p_back_partial;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_rise && mode_r == MODE_WAKE_PART && !fl_s_r.reach2) |=> mode_r == MODE_PARTIAL;
  endproperty
  a_back_partial: assert property (p_back_partial)
    else $error("glitch woke the device");

  property p_wake_part;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_fall && mode_r == MODE_PARTIAL) |=> analog_en_o ##[1:3] powered_o;
  endproperty
  a_wake_part: assert property (p_wake_part)
    else $error("partial wake too slow");

  property p_commit;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_rise && fl_s_r.reach16) |=> res_r == $past(samp_r);
  endproperty
  a_commit: assert property (p_commit)
    else $error("result not committed");

  property p_abort;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (cs_rise && !fl_s_r.reach16) |=> $stable(res_r);
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted frame changed result");

endmodule // cs_timed_power_mode_control
